// ---- dmx_map.svh ----
// Register offsets, field positions and reset values of the DMA channel block
`ifndef DMX_MAP_SVH
`define DMX_MAP_SVH

// ==========================================================================
// Global registers (byte addresses)
`define DMX_GE_ADDR 12'h000
`define DMX_GS_ADDR 12'h004
`define DMX_GIE_ADDR 12'h008
`define DMX_GSWR_ADDR 12'h00c
`define DMX_GSWS_ADDR 12'h010

// ==========================================================================
// Channel window: address bits [11:9] select it, [8:6] the channel, [5:0] the offset
`define DMX_CH_WINDOW 3'h1
`define DMX_CIE_OFS 6'h00
`define DMX_CIS_OFS 6'h04
`define DMX_CSA_OFS 6'h08
`define DMX_CDA_OFS 6'h0c
`define DMX_CUBC_OFS 6'h10
`define DMX_CC_OFS 6'h14
`define DMX_CNDC_OFS 6'h18
`define DMX_CBC_OFS 6'h1c
`define DMX_CDS_OFS 6'h20
`define DMX_CSUS_OFS 6'h24
`define DMX_CDUS_OFS 6'h28

// ==========================================================================
// Channel configuration fields
`define DMX_CC_TYPE 0
`define DMX_CC_MEMORY_BURST_SIZE_LSB 1
`define DMX_CC_DIR 4
`define DMX_CC_SECURE 5
`define DMX_CC_CHUNK_LSB 8
`define DMX_CC_WIDTH_LSB 11
`define DMX_CC_RDPORT 13
`define DMX_CC_WRPORT 14
`define DMX_CC_SAM_LSB 16
`define DMX_CC_DAM_LSB 18
`define DMX_CC_SOFT 23
`define DMX_CC_LINE_LSB 24
`define DMX_AM_FIXED 2'h0
`define DMX_CHUNK_MAX_LOG2 3'h4
`define DMX_MICROBLOCK_LENGTH_W 24
`define DMX_REG_RST 32'h0000_0000

`endif

// ---- dmx_pkg.sv ----
// Types shared by the DMA channel block
`default_nettype none
package dmx_pkg;
  typedef enum logic [1:0] {
    DMX_IDLE = 2'b00,
    DMX_READ = 2'b01,
    DMX_WRITE = 2'b10
  } dmx_state_type;
endpackage : dmx_pkg
`default_nettype wire

// ---- dmx_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous request pins
`timescale 1ns/100ps
`default_nettype none
module dmx_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Async in, synchronised out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  if (W < 1) begin : g_bad_w
    $error("dmx_sync: W must be at least 1");
  end
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule : dmx_sync
`default_nettype wire

// ---- dmx_channel.sv ----
// Multi-channel DMA engine with peripheral and software pacing
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dmx_map.svh"
module dmx_channel #(
  parameter int NCH = 4,
  parameter int NPER = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [11:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Peripheral request pins
  input wire logic [NPER-1:0] i_periph_req,
  // Memory read master
  output logic o_rd_req,
  output logic [31:0] o_rd_addr,
  output logic o_rd_port,
  input wire logic i_rd_ack,
  input wire logic [31:0] i_rd_data,
  // Memory write master
  output logic o_wr_req,
  output logic [31:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic o_wr_port,
  input wire logic i_wr_ack,
  // Access attributes
  output logic [1:0] o_item_width,
  output logic o_secure,
  output logic o_periph_access,
  output logic [4:0] o_burst_len,
  // Interrupt
  output logic o_irq
);
  import dmx_pkg::*;

  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;

  // Channel index is three address bits and the line field seven bits wide
  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("dmx_channel: NCH must be 1..8");
  end
  if (NPER < 1 || NPER > 128) begin : g_bad_nper
    $error("dmx_channel: NPER must be 1..128");
  end

  // ========================================================================
  // Storage
  logic [NCH-1:0] busy_r, bie_r, bis_r, gie_r, soft_pacing_sel_r;
  logic [31:0] src_r [NCH];
  logic [31:0] dst_r [NCH];
  logic [31:0] cc_r [NCH];
  logic [31:0] ndc_r [NCH];
  logic [31:0] bc_r [NCH];
  logic [31:0] ds_r [NCH];
  logic [31:0] sus_r [NCH];
  logic [31:0] dus_r [NCH];
  logic [`DMX_MICROBLOCK_LENGTH_W-1:0] microblock_length_r [NCH];
  logic [NPER-1:0] req_sync, req_prev_r, hwpend_r;
  dmx_state_type st_r;
  logic [CHW-1:0] act_ch_r;
  logic [4:0] seg_r;
  logic [31:0] data_r, rdata_r;

  // ========================================================================
  // Register decode
  logic ch_hit;
  logic [2:0] rch;
  logic [5:0] ofs;
  logic [NCH-1:0] ch_wr, cis_rd;
  always_comb begin
    ch_hit = (i_reg_addr[11:9] == `DMX_CH_WINDOW) && (32'(i_reg_addr[8:6]) < NCH);
    rch = i_reg_addr[8:6];
    ofs = i_reg_addr[5:0];
    for (int c = 0; c < NCH; c++) begin
      ch_wr[c] = i_reg_wr && ch_hit && (32'(rch) == c);
      cis_rd[c] = i_reg_rd && ch_hit && (32'(rch) == c) && (ofs == `DMX_CIS_OFS);
    end
  end
  wire logic glb_wr = i_reg_wr && !i_reg_addr[11];

  // ========================================================================
  // Pacing: edge detect of synchronised lines, channel readiness, arbitration
  dmx_sync #(.W(NPER)) u_req_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(i_periph_req),
    .o_sync(req_sync)
  );

  logic [NCH-1:0] rdy, lin0, rem0;
  logic pick_vld;
  logic [CHW-1:0] pick_ch;
  always_comb begin
    pick_vld = 1'b0;
    pick_ch = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      lin0[c] = ~|{ndc_r[c], bc_r[c], ds_r[c], sus_r[c], dus_r[c]};
      rem0[c] = (microblock_length_r[c] == '0);
      rdy[c] = rem0[c] || !cc_r[c][`DMX_CC_TYPE];
      if (cc_r[c][`DMX_CC_SOFT]) begin
        rdy[c] = rdy[c] || soft_pacing_sel_r[c];
      end else begin
        for (int l = 0; l < NPER; l++) begin
          if (32'(cc_r[c][`DMX_CC_LINE_LSB +: 7]) == l && hwpend_r[l]) begin
            rdy[c] = 1'b1;
          end
        end
      end
      if (busy_r[c] && rdy[c]) begin
        pick_vld = 1'b1;
        pick_ch = CHW'(c);
      end
    end
  end

  // ========================================================================
  // Engine events
  wire logic [CHW-1:0] ev_ch = (st_r == DMX_IDLE) ? pick_ch : act_ch_r;
  wire logic [31:0] ev_cc = cc_r[ev_ch];
  wire logic [31:0] act_cc = cc_r[act_ch_r];
  wire logic wr_done = (st_r == DMX_WRITE) && i_wr_ack;
  logic blk_end, chunk_end;
  logic [NCH-1:0] blk_vec, clr_sw;
  logic [NPER-1:0] clr_line;
  logic [2:0] chunk_log2;
  logic [4:0] seg_len, seg_ld;
  logic [31:0] step;
  always_comb begin
    blk_end = ((st_r == DMX_IDLE) && pick_vld && rem0[pick_ch]) ||
              (wr_done && (microblock_length_r[act_ch_r] == `DMX_MICROBLOCK_LENGTH_W'(1)));
    chunk_end = blk_end || (wr_done && (seg_r == 5'h01));
    blk_vec = '0;
    clr_sw = '0;
    clr_line = '0;
    blk_vec[ev_ch] = blk_end;
    if (chunk_end && ev_cc[`DMX_CC_TYPE] && ev_cc[`DMX_CC_SOFT]) begin
      clr_sw[ev_ch] = 1'b1;
    end
    for (int l = 0; l < NPER; l++) begin
      if (chunk_end && ev_cc[`DMX_CC_TYPE] && !ev_cc[`DMX_CC_SOFT] &&
          32'(ev_cc[`DMX_CC_LINE_LSB +: 7]) == l) begin
        clr_line[l] = 1'b1;
      end
    end
    // Chunk field above the largest size saturates rather than wrapping
    chunk_log2 = (ev_cc[`DMX_CC_CHUNK_LSB +: 3] > `DMX_CHUNK_MAX_LOG2) ?
                 `DMX_CHUNK_MAX_LOG2 : ev_cc[`DMX_CC_CHUNK_LSB +: 3];
    if (ev_cc[`DMX_CC_TYPE]) begin
      seg_len = 5'h01 << chunk_log2;
    end else begin
      seg_len = 5'h01 << ev_cc[`DMX_CC_MEMORY_BURST_SIZE_LSB +: 2];
    end
    seg_ld = (microblock_length_r[ev_ch] < `DMX_MICROBLOCK_LENGTH_W'(seg_len)) ? microblock_length_r[ev_ch][4:0] : seg_len;
    step = 32'h0000_0001 << act_cc[`DMX_CC_WIDTH_LSB +: 2];
  end

  // ========================================================================
  // Sequencer: one item at a time, read then write
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= DMX_IDLE;
      act_ch_r <= '0;
      seg_r <= 5'h00;
    end else begin
      case (st_r)
        DMX_IDLE: begin
          if (pick_vld && !rem0[pick_ch]) begin
            act_ch_r <= pick_ch;
            seg_r <= seg_ld;
            st_r <= DMX_READ;
          end
        end
        DMX_READ: begin
          if (i_rd_ack) begin
            st_r <= DMX_WRITE;
          end
        end
        DMX_WRITE: begin
          if (i_wr_ack) begin
            seg_r <= seg_r - 5'h01;
            st_r <= chunk_end ? DMX_IDLE : DMX_READ;
          end
        end
        default: begin
          st_r <= DMX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      data_r <= 32'h0000_0000;
    end else if (st_r == DMX_READ && i_rd_ack) begin
      data_r <= i_rd_data;
    end
  end

  // ========================================================================
  // Channel registers; engine updates win over a software write in the same cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int c = 0; c < NCH; c++) begin
        src_r[c] <= `DMX_REG_RST;
        dst_r[c] <= `DMX_REG_RST;
        microblock_length_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_wr[c] && ofs == `DMX_CSA_OFS) src_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CDA_OFS) dst_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CUBC_OFS) microblock_length_r[c] <= i_reg_wdata[`DMX_MICROBLOCK_LENGTH_W-1:0];
      end
      if (wr_done) begin
        microblock_length_r[act_ch_r] <= microblock_length_r[act_ch_r] - `DMX_MICROBLOCK_LENGTH_W'(1);
        if (act_cc[`DMX_CC_SAM_LSB +: 2] != `DMX_AM_FIXED) begin
          src_r[act_ch_r] <= src_r[act_ch_r] + step;
        end
        if (act_cc[`DMX_CC_DAM_LSB +: 2] != `DMX_AM_FIXED) begin
          dst_r[act_ch_r] <= dst_r[act_ch_r] + step;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int c = 0; c < NCH; c++) begin
        cc_r[c] <= `DMX_REG_RST;
        ndc_r[c] <= `DMX_REG_RST;
        bc_r[c] <= `DMX_REG_RST;
        ds_r[c] <= `DMX_REG_RST;
        sus_r[c] <= `DMX_REG_RST;
        dus_r[c] <= `DMX_REG_RST;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_wr[c] && ofs == `DMX_CC_OFS) cc_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CNDC_OFS) ndc_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CBC_OFS) bc_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CDS_OFS) ds_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CSUS_OFS) sus_r[c] <= i_reg_wdata;
        if (ch_wr[c] && ofs == `DMX_CDUS_OFS) dus_r[c] <= i_reg_wdata;
      end
    end
  end

  // ========================================================================
  // Flags; every hardware set wins over a clear in the same cycle
  logic [NCH-1:0] ge_start, sw_set, bie_wr;
  always_comb begin
    ge_start = (glb_wr && i_reg_addr == `DMX_GE_ADDR) ? i_reg_wdata[NCH-1:0] : '0;
    sw_set = (glb_wr && i_reg_addr == `DMX_GSWR_ADDR) ? i_reg_wdata[NCH-1:0] : '0;
    for (int c = 0; c < NCH; c++) begin
      bie_wr[c] = ch_wr[c] && (ofs == `DMX_CIE_OFS);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_r <= '0;
      bis_r <= '0;
      soft_pacing_sel_r <= '0;
      hwpend_r <= '0;
      req_prev_r <= '0;
    end else begin
      // A start is refused while list or stride registers hold anything
      busy_r <= (busy_r & ~blk_vec) | (ge_start & lin0);
      bis_r <= (bis_r & ~cis_rd) | blk_vec;
      soft_pacing_sel_r <= (soft_pacing_sel_r & ~clr_sw) | sw_set;
      req_prev_r <= req_sync;
      hwpend_r <= (hwpend_r & ~clr_line) | (req_sync & ~req_prev_r);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bie_r <= '0;
      gie_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (bie_wr[c]) bie_r[c] <= i_reg_wdata[0];
      end
      if (glb_wr && i_reg_addr == `DMX_GIE_ADDR) gie_r <= i_reg_wdata[NCH-1:0];
    end
  end

  // ========================================================================
  // Read port: data in the cycle after the strobe only
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (ch_hit) begin
      case (ofs)
        `DMX_CIE_OFS: rd_val = {31'h0, bie_r[rch[CHW-1:0]]};
        `DMX_CIS_OFS: rd_val = {31'h0, bis_r[rch[CHW-1:0]]};
        `DMX_CSA_OFS: rd_val = src_r[rch[CHW-1:0]];
        `DMX_CDA_OFS: rd_val = dst_r[rch[CHW-1:0]];
        `DMX_CUBC_OFS: rd_val = 32'(microblock_length_r[rch[CHW-1:0]]);
        `DMX_CC_OFS: rd_val = cc_r[rch[CHW-1:0]];
        `DMX_CNDC_OFS: rd_val = ndc_r[rch[CHW-1:0]];
        `DMX_CBC_OFS: rd_val = bc_r[rch[CHW-1:0]];
        `DMX_CDS_OFS: rd_val = ds_r[rch[CHW-1:0]];
        `DMX_CSUS_OFS: rd_val = sus_r[rch[CHW-1:0]];
        `DMX_CDUS_OFS: rd_val = dus_r[rch[CHW-1:0]];
        default: rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (i_reg_addr)
        `DMX_GS_ADDR: rd_val = 32'(busy_r);
        `DMX_GIE_ADDR: rd_val = 32'(gie_r);
        `DMX_GSWS_ADDR: rd_val = 32'(soft_pacing_sel_r);
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= i_reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  // ========================================================================
  // Outputs
  always_comb begin
    o_reg_rdata = rdata_r;
    o_rd_req = (st_r == DMX_READ);
    o_wr_req = (st_r == DMX_WRITE);
    o_rd_addr = src_r[act_ch_r];
    o_wr_addr = dst_r[act_ch_r];
    o_wr_data = data_r;
    o_rd_port = act_cc[`DMX_CC_RDPORT];
    o_wr_port = act_cc[`DMX_CC_WRPORT];
    o_item_width = act_cc[`DMX_CC_WIDTH_LSB +: 2];
    o_secure = act_cc[`DMX_CC_SECURE];
    // Direction one: memory to peripheral, so the write side is the peripheral
    o_periph_access = act_cc[`DMX_CC_TYPE] &&
                      (o_wr_req ? act_cc[`DMX_CC_DIR] : !act_cc[`DMX_CC_DIR]);
    o_burst_len = seg_r;
    o_irq = |(bis_r & bie_r & gie_r);
  end

  // ========================================================================
  // Assertions
  property p_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (ge_start[0] && lin0[0] && !blk_vec[0]) |=> busy_r[0];
  endproperty
  a_start: assert property (p_start) else $error("start did not set busy");
  property p_blk;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (blk_end && !ge_start[ev_ch]) |=> (bis_r[$past(ev_ch)] && !busy_r[$past(ev_ch)]);
  endproperty
  a_blk: assert property (p_blk) else $error("block end flags wrong");
  property p_irq;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (blk_vec[0] && bie_r[0] && gie_r[0] && !glb_wr) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong");
  property p_sw;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (sw_set != '0) |=> ((soft_pacing_sel_r & $past(sw_set)) == $past(sw_set)) ##1
      (((soft_pacing_sel_r | $past(clr_sw)) & $past(sw_set, 2)) == $past(sw_set, 2));
  endproperty
  a_sw: assert property (p_sw) else $error("soft request lost");
  property p_gsws;
    @(posedge i_core_clk) disable iff (!i_nrst)
    ((~soft_pacing_sel_r & $past(soft_pacing_sel_r)) != '0) |-> $past(chunk_end);
  endproperty
  a_gsws: assert property (p_gsws) else $error("pending cleared without service");
  property p_cis;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cis_rd[0] && bis_r[0] && !blk_vec[0]) |=> (o_reg_rdata[0] && !bis_r[0]);
  endproperty
  a_cis: assert property (p_cis) else $error("status read did not clear");
  property p_m2m;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r == DMX_IDLE && busy_r[0] && !cc_r[0][`DMX_CC_TYPE] && !rem0[0]) |=> st_r == DMX_READ;
  endproperty
  a_m2m: assert property (p_m2m) else $error("memory copy did not start");
  property p_adv;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (wr_done && act_cc[`DMX_CC_SAM_LSB +: 2] != `DMX_AM_FIXED && !ch_wr[act_ch_r])
      |=> src_r[$past(act_ch_r)] == $past(src_r[act_ch_r]) + $past(step);
  endproperty
  a_adv: assert property (p_adv) else $error("source address did not advance");
  property p_hold;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (o_rd_req && !i_rd_ack) |=> (o_rd_req && $stable(o_secure) && $stable(o_rd_port));
  endproperty
  a_hold: assert property (p_hold) else $error("read request dropped");
  property p_seg;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st_r == DMX_IDLE && pick_vld && ev_cc[`DMX_CC_TYPE] && !rem0[pick_ch])
      |=> (seg_r != 5'h00 && seg_r <= 5'h10);
  endproperty
  a_seg: assert property (p_seg) else $error("chunk size out of range");
  c_blk: cover property (@(posedge i_core_clk) disable iff (!i_nrst) blk_end && o_irq == 1'b0);
  c_soft: cover property (@(posedge i_core_clk) disable iff (!i_nrst) clr_sw != '0);
  c_hw: cover property (@(posedge i_core_clk) disable iff (!i_nrst) clr_line != '0);
  c_cis: cover property (@(posedge i_core_clk) disable iff (!i_nrst) cis_rd[0] && bis_r[0]);
endmodule : dmx_channel
`default_nettype wire

// ---- dmx_mem_model.sv ----
// Memory slave and write recorder facing the DMA channel's masters
`timescale 1ns/100ps
`default_nettype none
module dmx_mem_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Read side
  input wire logic i_rd_req,
  input wire logic [31:0] i_rd_addr,
  output logic o_rd_ack,
  output logic [31:0] o_rd_data,
  // Write side
  input wire logic i_wr_req,
  input wire logic [31:0] i_wr_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic [5:0] i_wr_attr,
  output logic o_wr_ack,
  // Bench control and record
  input wire logic i_slow,
  output logic [31:0] o_last_addr,
  output logic [31:0] o_last_data,
  output logic [5:0] o_last_attr,
  output logic [7:0] o_wr_count
);
  logic [1:0] wait_r;
  // Slow mode keeps each access waiting two cycles
  assign o_rd_ack = i_rd_req && (!i_slow || wait_r == 2'h2);
  assign o_wr_ack = i_wr_req && (!i_slow || wait_r == 2'h2);
  // Data is only good with the ack, so garbage shows otherwise
  assign o_rd_data = o_rd_ack ? (i_rd_addr ^ 32'h5a5a_0000) : (~i_rd_addr ^ {30'h0, wait_r});
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_r <= 2'h0;
    end else if (o_rd_ack || o_wr_ack || !(i_rd_req || i_wr_req)) begin
      wait_r <= 2'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wr_count <= 8'h0;
      o_last_addr <= 32'h0;
      o_last_data <= 32'h0;
      o_last_attr <= 6'h0;
    end else if (o_wr_ack) begin
      o_wr_count <= o_wr_count + 8'h1;
      o_last_addr <= i_wr_addr;
      o_last_data <= i_wr_data;
      o_last_attr <= i_wr_attr;
    end
  end
endmodule : dmx_mem_model
`default_nettype wire

// ---- peripheral_sync_dma_channel_tb_top.sv ----
// Self-checking bench for the DMA channel block
`timescale 1ns/100ps
`default_nettype none
module peripheral_sync_dma_channel_tb_top;
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, rdata, rd_addr, rd_data, wr_addr, wr_data, l_addr, l_data;
  logic [15:0] preq = 16'h0;
  logic rd_req, rd_port, rd_ack, wr_req, wr_port, wr_ack, secure, pacc, irq;
  logic [1:0] width;
  logic [4:0] blen;
  logic [5:0] l_attr;
  logic [7:0] wcnt;
  int bad_count = 0, num_checks = 0;
  always #4 clk = ~clk;
  dmx_channel i_dmx_channel (.i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_periph_req(preq), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_rd_port(rd_port),
    .i_rd_ack(rd_ack), .i_rd_data(rd_data), .o_wr_req(wr_req), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_wr_port(wr_port), .i_wr_ack(wr_ack), .o_item_width(width),
    .o_secure(secure), .o_periph_access(pacc), .o_burst_len(blen), .o_irq(irq));
  dmx_mem_model i_dmx_mem_model (.i_core_clk(clk), .i_nrst(nrst), .i_rd_req(rd_req),
    .i_rd_addr(rd_addr), .o_rd_ack(rd_ack), .o_rd_data(rd_data), .i_wr_req(wr_req),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_wr_attr({pacc, rd_port, wr_port, secure, width}),
    .o_wr_ack(wr_ack), .i_slow(slow), .o_last_addr(l_addr), .o_last_data(l_data),
    .o_last_attr(l_attr), .o_wr_count(wcnt));
  // ==========================================================================
  // Bus tasks: strobes are set at entry, so back-to-back calls never clash
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    #1;
    v = rdata;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdc
  task automatic wait_free(input logic [31:0] m);
    logic [31:0] v;
    for (int i = 0; i < 100; i++) begin
      rd(12'h004, v);
      if ((v & m) == 32'h0) return;
    end
    bad_count++;
    finish_test();
  endtask : wait_free
  task automatic wait_wr(input logic [7:0] n);
    for (int i = 0; i < 100; i++) begin
      tick();
      if (wcnt === n) return;
    end
    bad_count++;
    finish_test();
  endtask : wait_wr
  task automatic setup(input logic [11:0] b, input logic [31:0] s, d, n, cc);
    logic [31:0] v;
    rd(b + 12'h04, v);
    wr(b + 12'h08, s);
    wr(b + 12'h0c, d);
    wr(b + 12'h10, n);
    wr(b + 12'h14, cc);
    wr(b, 32'h1);
  endtask : setup
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rdc(12'h004, 32'h0);
    rdc(12'h010, 32'h0);
    rdc(12'hffc, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_reset
  task automatic t_copy;
    setup(12'h200, 32'h100, 32'h800, 32'h2, 32'h0005_3022);
    wr(12'h008, 32'h1);
    wr(12'h000, 32'h1);
    rdc(12'h004, 32'h1);
    chk({27'h0, blen}, 32'h2);
    wait_free(32'h1);
    chk({24'h0, wcnt}, 32'h2);
    chk(l_addr, 32'h804);
    chk(l_data, 32'h5a5a_0104);
    chk({26'h0, l_attr}, 32'h16);
    rdc(12'h210, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdc(12'h204, 32'h1);
    rdc(12'h204, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_copy
  task automatic t_soft;
    slow <= 1'b1;
    setup(12'h240, 32'h300, 32'h900, 32'h1, 32'h7f80_0801);
    wr(12'h000, 32'h2);
    repeat (6) tick();
    chk({24'h0, wcnt}, 32'h2);
    wr(12'h00c, 32'h2);
    rdc(12'h010, 32'h2);
    wait_free(32'h2);
    rdc(12'h010, 32'h0);
    chk({26'h0, l_attr}, 32'h01);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h244, 32'h1);
    slow <= 1'b0;
  endtask : t_soft
  task automatic t_hw;
    setup(12'h280, 32'h400, 32'ha00, 32'h2, 32'h0300_5011);
    wr(12'h000, 32'h4);
    preq[3] <= 1'b1;
    wait_wr(8'h4);
    preq[3] <= 1'b0;
    repeat (6) tick();
    rdc(12'h004, 32'h4);
    preq[3] <= 1'b1;
    wait_wr(8'h5);
    preq[3] <= 1'b0;
    wait_free(32'h4);
    chk(l_addr, 32'ha00);
    chk(l_data, 32'h5a5a_0400);
    chk({26'h0, l_attr}, 32'h2a);
  endtask : t_hw
  task automatic t_refuse;
    wr(12'h2d8, 32'h1);
    wr(12'h000, 32'h8);
    rdc(12'h004, 32'h0);
    rdc(12'h2d8, 32'h1);
  endtask : t_refuse
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_copy();
    t_soft();
    t_hw();
    t_refuse();
    tick();
    finish_test();
  end
endmodule : peripheral_sync_dma_channel_tb_top
`default_nettype wire
